// ==== rtl/cie_exec.sv ====
// Execution unit for sleep, subtract-from-literal, nibble swap and exclusive OR.
// Assumes a decoder presents one instruction per cycle with the file operand already read.
// Notes on behaviour
// - Sleep clears the watchdog counter and its prescaler to zero.
// - Sleep sets the time-out flag, clears power-down flag, nothing else.
// - After sleep updates, the core enters sleep with the oscillator halted.
// - Subtract-from-literal computes immediate minus accumulator into the accumulator.
// - Carry and half-carry are zero when accumulator part exceeds literal part.
// - Nibble swap exchanges the upper and lower four-bit halves, no flags.
// - Destination bit zero writes accumulator, one writes addressed file register.
// - Exclusive OR with immediate writes accumulator, updates only zero.
// - Exclusive OR with file writes the chosen destination, updates only zero.
`timescale 1ns/1ns
module cie_exec
    import cie_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Instruction and operand
    input wire cie_instr_s instr_i,
    input wire logic [7:0] file_rdata_i,
    // Wake request ends sleep
    input wire logic wake_i,
    // Architectural state
    output logic [7:0] acc_o,
    output cie_flags_s flags_o,
    output cie_fwr_s fwr_o,
    // Watchdog clear and sleep control
    output logic wdt_clr_o,
    output logic [7:0] watchdog_counter_load_o,
    output logic [7:0] presc_load_o,
    output logic sleep_o,
    output logic osc_run_o
);
    logic [7:0] acc_q;
    cie_flags_s flags_q;
    cie_fwr_s fwr_q;
    logic wdt_clr_q;
    logic sleep_q;
    logic [7:0] alu_res;
    logic alu_c;
    logic alu_dc;
    logic alu_z;

    cie_alu u_alu (
        .op_i(instr_i.op),
        .acc_i(acc_q),
        .imm_i(instr_i.imm),
        .file_i(file_rdata_i),
        .res_o(alu_res),
        .carry_o(alu_c),
        .half_carry_o(alu_dc),
        .zero_o(alu_z)
    );

    // Instructions are ignored while asleep; the clock would be gated in silicon.
    wire go = instr_i.valid & ~sleep_q;
    wire is_sleep = go & (instr_i.op == CIE_OP_SLEEP);
    wire is_subl = go & (instr_i.op == CIE_OP_SUBL);
    wire is_swap = go & (instr_i.op == CIE_OP_SWAP);
    wire is_xorl = go & (instr_i.op == CIE_OP_XORL);
    wire is_xorf = go & (instr_i.op == CIE_OP_XORF);
    wire file_op = is_swap | is_xorf;
    wire to_file = file_op & (instr_i.dest == CIE_DEST_FILE);
    wire to_acc = is_subl | is_xorl | (file_op & (instr_i.dest == CIE_DEST_ACC));
    wire upd_z = is_subl | is_xorl | is_xorf;

    logic [7:0] acc_d;
    cie_flags_s flags_d;
    cie_fwr_s fwr_d;
    assign acc_d = to_acc ? alu_res : acc_q;
    assign fwr_d = '{we: to_file, addr: instr_i.faddr, data: alu_res};
    assign flags_d = '{
        carry: is_subl ? alu_c : flags_q.carry,
        half_carry_flag: is_subl ? alu_dc : flags_q.half_carry_flag,
        zero: upd_z ? alu_z : flags_q.zero,
        timeout_flag_n: is_sleep ? 1'b1 : flags_q.timeout_flag_n,
        powerdown_flag_n: is_sleep ? 1'b0 : flags_q.powerdown_flag_n
    };

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_q <= CIE_ACC_RESET;
            flags_q <= '{1'b0, 1'b0, 1'b0, CIE_TO_RESET, CIE_PD_RESET};
            fwr_q <= '0;
            wdt_clr_q <= 1'b0;
            sleep_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            flags_q <= flags_d;
            fwr_q <= fwr_d;
            wdt_clr_q <= is_sleep;
            sleep_q <= is_sleep | (sleep_q & ~wake_i);
        end
    end

    assign acc_o = acc_q;
    assign flags_o = flags_q;
    assign fwr_o = fwr_q;
    assign wdt_clr_o = wdt_clr_q;
    assign watchdog_counter_load_o = CIE_WDT_CLEAR;
    assign presc_load_o = CIE_PRESC_CLEAR;
    assign sleep_o = sleep_q;
    assign osc_run_o = ~sleep_q;

    a_sleep_wdt: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        is_sleep |=> wdt_clr_o && sleep_o && !osc_run_o)
        else $error("sleep did not clear watchdog and halt");
    a_sleep_flags: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        is_sleep |=> flags_o.timeout_flag_n && !flags_o.powerdown_flag_n
            && flags_o.zero == $past(flags_q.zero))
        else $error("sleep flag update wrong");
    a_sleep_stays: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        sleep_o && !wake_i |=> sleep_o)
        else $error("sleep left without wake");
    a_sub_result: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        is_subl |=> acc_o == 8'($past(instr_i.imm) - $past(acc_q)))
        else $error("subtract result wrong");
    a_sub_carry: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        is_subl |=> flags_o.carry == ($past(acc_q) <= $past(instr_i.imm)))
        else $error("subtract carry wrong");
    a_sub_halfc: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        is_subl |=> flags_o.half_carry_flag
            == ($past(acc_q[3:0]) <= $past(instr_i.imm[3:0])))
        else $error("subtract half carry wrong");
    a_swap_value: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        is_swap && instr_i.dest |=> fwr_o.we
            && fwr_o.data == {$past(file_rdata_i[3:0]), $past(file_rdata_i[7:4])}
            && $stable(flags_o))
        else $error("swap result or flags wrong");
    a_dest_acc: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        file_op && !instr_i.dest |=> !fwr_o.we && acc_o == fwr_o.data)
        else $error("destination accumulator wrong");
    a_xor_lit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        is_xorl |=> acc_o == ($past(acc_q) ^ $past(instr_i.imm))
            && flags_o.carry == $past(flags_q.carry))
        else $error("xor literal wrong");
    a_xor_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        is_xorf |=> flags_o.zero == (($past(acc_q) ^ $past(file_rdata_i)) == 8'h00))
        else $error("xor file zero wrong");
    a_file_addr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        to_file |=> fwr_o.addr == $past(instr_i.faddr))
        else $error("file address wrong");

    // Exclusive OR with a file operand, both destinations, and the flags it must leave alone.
    a_xorf_file: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        is_xorf && instr_i.dest |=> fwr_o.we
            && fwr_o.data == ($past(acc_q) ^ $past(file_rdata_i)))
        else $error("xor file write wrong");
    a_xorf_acc: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        is_xorf && !instr_i.dest |=> !fwr_o.we
            && acc_o == ($past(acc_q) ^ $past(file_rdata_i)))
        else $error("xor file accumulator wrong");
    a_xorf_keep: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        is_xorf |=> flags_o.carry == $past(flags_q.carry)
            && flags_o.half_carry_flag == $past(flags_q.half_carry_flag))
        else $error("xor file touched carry flags");

    // The zero flag follows the value that landed in the accumulator.
    a_xorl_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        is_xorl |=> flags_o.zero == (acc_o == 8'h00))
        else $error("xor literal zero wrong");
    a_sub_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        is_subl |=> flags_o.zero == (acc_o == 8'h00))
        else $error("subtract zero wrong");

    // Swap to the accumulator must not disturb any flag.
    a_swap_acc: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        is_swap && !instr_i.dest |=> !fwr_o.we
            && acc_o == {$past(file_rdata_i[3:0]), $past(file_rdata_i[7:4])}
            && $stable(flags_o))
        else $error("swap to accumulator wrong");

    // A write to the file side leaves the accumulator as it was.
    a_file_keep: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        to_file |=> acc_o == $past(acc_q))
        else $error("file write changed accumulator");
    a_no_file_wr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !to_file |=> !fwr_o.we)
        else $error("spurious file write");

    // Sleep keeps the arithmetic flags and the accumulator.
    a_sleep_keep: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        is_sleep |=> flags_o.carry == $past(flags_q.carry)
            && flags_o.half_carry_flag == $past(flags_q.half_carry_flag)
            && acc_o == $past(acc_q) && !fwr_o.we)
        else $error("sleep touched other state");
    a_wdt_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !is_sleep |=> !wdt_clr_o)
        else $error("watchdog clear without sleep");
    a_load_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        watchdog_counter_load_o == 8'h00 && presc_load_o == 8'h00)
        else $error("watchdog load value not zero");

    // While asleep nothing executes; a wake request restarts the oscillator.
    a_asleep_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        sleep_o |=> $stable(acc_o) && !fwr_o.we && !wdt_clr_o)
        else $error("instruction executed while asleep");
    a_wake_exit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        sleep_o && wake_i |=> !sleep_o && osc_run_o)
        else $error("wake did not end sleep");
    a_osc_inverse: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        osc_run_o == !sleep_o)
        else $error("oscillator run not inverse of sleep");

    c_sleep: cover property (@(posedge clk_i) disable iff (!rst_b_i) is_sleep ##1 wake_i);
    c_sub_borrow: cover property (@(posedge clk_i) disable iff (!rst_b_i) is_subl && !alu_c);
    c_swap_acc: cover property (@(posedge clk_i) disable iff (!rst_b_i) is_swap && !instr_i.dest);
    c_xor_zero: cover property (@(posedge clk_i) disable iff (!rst_b_i) is_xorf && alu_z);
    c_swap_file: cover property (@(posedge clk_i) disable iff (!rst_b_i) is_swap && instr_i.dest);
endmodule

// ==== rtl/cie_pkg.sv ====
// Package for the instruction subset execution block: opcodes, flag layout, resets.
// Assumes a single 100 MHz core clock domain and an upstream decoder.
package cie_pkg;
    localparam logic [7:0] CIE_WDT_CLEAR = 8'h00;
    localparam logic [7:0] CIE_PRESC_CLEAR = 8'h00;
    localparam logic [7:0] CIE_ACC_RESET = 8'h00;
    localparam int CIE_LO_NIB_MSB = 3;
    localparam int CIE_HI_NIB_LSB = 4;
    localparam logic CIE_DEST_ACC = 1'b0;
    localparam logic CIE_DEST_FILE = 1'b1;
    localparam logic CIE_TO_RESET = 1'b1;
    localparam logic CIE_PD_RESET = 1'b1;

    typedef enum logic [4:0] {
        CIE_OP_SLEEP = 5'h01,
        CIE_OP_SUBL = 5'h02,
        CIE_OP_SWAP = 5'h04,
        CIE_OP_XORL = 5'h08,
        CIE_OP_XORF = 5'h10
    } cie_op_e;

    typedef struct packed {
        logic valid;
        cie_op_e op;
        logic [7:0] imm;
        logic [6:0] faddr;
        logic dest;
    } cie_instr_s;

    typedef struct packed {
        logic carry;
        logic half_carry_flag;
        logic zero;
        logic timeout_flag_n;
        logic powerdown_flag_n;
    } cie_flags_s;

    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } cie_fwr_s;
endpackage

// ==== rtl/cie_alu.sv ====
// Combinational arithmetic unit for the subset: subtract, swap, exclusive OR.
// Assumes operands are stable within the cycle; no state is kept here.
`timescale 1ns/1ns
module cie_alu
    import cie_pkg::*;
(
    // Operation select and operands
    input wire cie_op_e op_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] imm_i,
    input wire logic [7:0] file_i,
    // Result and flag candidates
    output logic [7:0] res_o,
    output logic carry_o,
    output logic half_carry_o,
    output logic zero_o
);
    wire [8:0] sub_full = {1'b0, imm_i} - {1'b0, acc_i};
    wire [4:0] sub_low = {1'b0, imm_i[CIE_LO_NIB_MSB:0]} - {1'b0, acc_i[CIE_LO_NIB_MSB:0]};
    wire [7:0] swapped = {file_i[CIE_LO_NIB_MSB:0], file_i[7:CIE_HI_NIB_LSB]};
    wire [7:0] xor_l = acc_i ^ imm_i;
    wire [7:0] xor_f = acc_i ^ file_i;

    // A borrow out means the accumulator exceeded the literal, so carry is the borrow inverted.
    assign carry_o = ~sub_full[8];
    assign half_carry_o = ~sub_low[4];
    assign res_o = (op_i == CIE_OP_SUBL) ? sub_full[7:0] :
                   (op_i == CIE_OP_SWAP) ? swapped :
                   (op_i == CIE_OP_XORL) ? xor_l : xor_f;
    assign zero_o = (res_o == 8'h00);
endmodule

// ==== verif/cie_exec_tb.sv ====
// Self-checking bench for the instruction subset execution unit.
// Assumes the unit alone, one 100 MHz clock, and the file operand supplied by the bench.
`timescale 1ns/1ns
module cie_exec_tb
    import cie_pkg::*;
;
    logic clk_i;
    logic rst_b_i;
    logic wake_q;
    cie_instr_s instr_q;
    logic [7:0] file_q;
    logic [7:0] acc_e;
    logic c_e, dc_e, z_e, to_e, pd_e;
    int err_count, tests_run;
    int cyc = 0;
    logic [7:0] acc_o, wdl_o, prl_o;
    cie_flags_s flags_o;
    cie_fwr_s fwr_o;
    logic wdt_clr_o, sleep_o, osc_run_o;

    cie_exec cie_exec_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .instr_i(instr_q),
        .file_rdata_i(file_q), .wake_i(wake_q), .acc_o(acc_o), .flags_o(flags_o),
        .fwr_o(fwr_o), .wdt_clr_o(wdt_clr_o), .watchdog_counter_load_o(wdl_o),
        .presc_load_o(prl_o), .sleep_o(sleep_o), .osc_run_o(osc_run_o));

    task stop_test;
        $display("errors %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // Drives one instruction, works out its effect independently, then compares.
    task op(input cie_op_e o, input logic [7:0] imm, input logic [6:0] fa, input logic d,
            input logic [7:0] fd);
        logic [7:0] r;
        logic we;
        r = acc_e;
        case (o)
            CIE_OP_SUBL: begin
                r = imm - acc_e;
                c_e = (acc_e <= imm);
                dc_e = (acc_e[3:0] <= imm[3:0]);
            end
            CIE_OP_SWAP: r = {fd[3:0], fd[7:4]};
            CIE_OP_XORL: r = acc_e ^ imm;
            CIE_OP_XORF: r = acc_e ^ fd;
            default: begin
                to_e = 1'b1;
                pd_e = 1'b0;
            end
        endcase
        if (o inside {CIE_OP_SUBL, CIE_OP_XORL, CIE_OP_XORF})
            z_e = (r == 8'h00);
        we = d && (o inside {CIE_OP_SWAP, CIE_OP_XORF});
        if (o inside {CIE_OP_SUBL, CIE_OP_XORL} || (o inside {CIE_OP_SWAP, CIE_OP_XORF} && !d))
            acc_e = r;
        @(posedge clk_i);
        instr_q <= '{1'b1, o, imm, fa, d};
        file_q <= fd;
        @(posedge clk_i);
        instr_q.valid <= 1'b0;
        #1;
        chk(acc_o, acc_e);
        chk(flags_o, {c_e, dc_e, z_e, to_e, pd_e});
        chk(fwr_o.we, we);
        if (we) chk(fwr_o, {1'b1, fa, r});
        chk(wdt_clr_o, o == CIE_OP_SLEEP);
        chk({sleep_o, osc_run_o}, {o == CIE_OP_SLEEP, o != CIE_OP_SLEEP});
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // The ceiling leaves ample margin over the roughly 46 cycles the sequence needs.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_count++;
            stop_test;
        end
    end

    initial begin
        {rst_b_i, wake_q, file_q, acc_e, c_e, dc_e, z_e} = '0;
        instr_q = '0;
        {to_e, pd_e} = 2'b11;
        err_count = 0;
        tests_run = 0;
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
        chk({acc_o, flags_o, sleep_o, osc_run_o}, {8'h00, 5'b00011, 2'b01});
        op(CIE_OP_XORL, 8'h03, 7'h00, 1'b0, 8'h00);
        op(CIE_OP_SUBL, 8'h05, 7'h00, 1'b0, 8'h00);
        op(CIE_OP_SUBL, 8'h01, 7'h00, 1'b0, 8'h00);
        op(CIE_OP_SUBL, 8'hf0, 7'h00, 1'b0, 8'h00);
        op(CIE_OP_SUBL, 8'hff, 7'h00, 1'b0, 8'h00);
        op(CIE_OP_SUBL, 8'h0e, 7'h00, 1'b0, 8'h00);
        op(CIE_OP_SWAP, 8'h00, 7'h7f, 1'b1, 8'ha5);
        op(CIE_OP_SWAP, 8'h00, 7'h12, 1'b0, 8'h3c);
        op(CIE_OP_XORF, 8'h00, 7'h00, 1'b1, 8'hc3);
        op(CIE_OP_XORF, 8'h00, 7'h40, 1'b0, 8'h0f);
        op(CIE_OP_XORL, 8'hcc, 7'h00, 1'b0, 8'h00);
        op(CIE_OP_SLEEP, 8'h00, 7'h00, 1'b0, 8'h00);
        chk({wdl_o, prl_o}, 16'h0000);
        // A sleeping core must not act on a presented instruction.
        @(posedge clk_i);
        instr_q <= '{1'b1, CIE_OP_XORF, 8'hff, 7'h05, 1'b1};
        @(posedge clk_i);
        instr_q.valid <= 1'b0;
        #1;
        chk({acc_o, fwr_o.we, wdt_clr_o, sleep_o}, {acc_e, 3'b001});
        @(posedge clk_i);
        wake_q <= 1'b1;
        @(posedge clk_i);
        wake_q <= 1'b0;
        #1;
        chk({sleep_o, osc_run_o}, 2'b01);
        op(CIE_OP_XORL, 8'h81, 7'h00, 1'b0, 8'h00);
        stop_test;
    end
endmodule
